/* File: dv/data_transmit_preamble_framer_bench.sv */
// self-checking bench for the preamble framer
`timescale 1ns/1ps
`default_nettype none
module data_transmit_preamble_framer_bench;
  reg         clk_sys, reset_n, tx_start, tx_stop;
  reg         data_in = 1'b0;
  wire        line, strobe, tx_active, data_phase, data_in_req, locked;
  wire [15:0] bit_count;
  integer     fail_count, comparisons;
  wire [15:0] outs = {11'h0, line, strobe, tx_active, data_phase, data_in_req};
  data_transmit_preamble_framer i_dut (.clk_sys, .reset_n, .tx_start, .tx_stop, .data_in,
    .digital_tx_line_out(line), .line_bit_strobe(strobe), .tx_active, .data_phase,
    .data_in_req);
  line_receiver i_rx (.clk_sys, .reset_n, .line_bit(line), .bit_strobe(strobe),
    .bit_count, .shift(), .locked, .code_seen());
  // ----
  // clock, data source and watchdog
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // new low-speed bit each time the framer takes one
  always @(posedge clk_sys) begin
    if (data_in_req) data_in <= ~data_in;
  end
  // cut a hang well past the expected 45k cycles
  initial begin
    #2000000;
    fail_count = fail_count + 1;
    report_and_stop;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // values read at the edge are those of the strobe cycle
  task wait_strobe(output integer c);
    begin
      c = 0;
      @(posedge clk_sys);
      while (strobe !== 1'b1 && c < 6000) begin
        c = c + 1;
        @(posedge clk_sys);
      end
    end
  endtask
  task apply_reset;
    begin
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(outs, 16'h0);
      reset_n <= 1'b1;
    end
  endtask
  // start held over four bits and stop raised in phasing: both must be ignored
  task run_phasing(input integer bits);
    integer c, i;
    begin
      @(posedge clk_sys);
      tx_start <= 1'b1;
      for (i = 0; i < bits; i = i + 1) begin
        wait_strobe(c);
        if (i > 0) chk(c[15:0], 16'h9c3);
        chk({15'h0, line}, {15'h0, ~i[0]});
        chk({14'h0, data_phase, tx_active}, 16'h1);
        chk({15'h0, data_in_req}, {15'h0, i[2:0] == 3'h7});
        if (i == 3) tx_start <= 1'b0;
        tx_stop <= (i >= 4 && i < 8);
      end
      repeat (2) @(posedge clk_sys);
      chk(bit_count, bits[15:0]);
      chk({15'h0, locked}, 16'h1);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    reset_n = 1'b0;
    tx_start = 1'b0;
    tx_stop = 1'b0;
    fail_count = 0;
    comparisons = 0;
    apply_reset;
    run_phasing(12);
    apply_reset;
    run_phasing(6);
    report_and_stop;
  end
endmodule
`default_nettype wire

/* File: dv/framer_checker.sv */
// assertion checker for the preamble framer
`timescale 1ns/1ps
`default_nettype none
`include "pt_framer_defs.vh"
module framer_checker (
  input wire clk_sys,
  input wire reset_n,
  input wire digital_tx_line_out,
  input wire line_bit_strobe,
  input wire tx_active,
  input wire data_phase
);
  localparam [14:0] cw = `CODE_WORD;
  reg        [11:0] gap;
  reg        [12:0] nb;
  // ----
  // bit spacing and bit position
  // ----
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 12'h0;
      nb  <= 13'h0;
    end else begin
      gap <= line_bit_strobe ? 12'h1 : gap + 12'h1;
      // saturate so a long data block cannot wrap back into the preamble range
      nb  <= !tx_active ? 13'h0 : (nb == 13'h1fff) ? nb : nb + {12'h0, line_bit_strobe};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_bit_period: assert property (line_bit_strobe && $past(tx_active) |-> gap == 12'h9c4)
    else $error("line bit period wrong");
  a_line_held: assert property ($changed(digital_tx_line_out) |-> line_bit_strobe || !tx_active)
    else $error("line bit changed between strobes");
  a_first_one: assert property ($rose(tx_active) |-> line_bit_strobe && digital_tx_line_out)
    else $error("transmission did not open with a one");
  a_phase_alt: assert property (line_bit_strobe && tx_active && nb < 13'h1000
    |-> digital_tx_line_out == !nb[0])
    else $error("phasing pattern broken");
  a_code_rep: assert property (line_bit_strobe && tx_active && nb >= 13'h1000 && nb < 13'h11c2
    |-> digital_tx_line_out == cw[14 - (nb - 13'h1000) % 15])
    else $error("code word repeat wrong");
  a_inv_word: assert property (line_bit_strobe && tx_active && nb >= 13'h11c2 && nb < 13'h11d1
    |-> digital_tx_line_out == !cw[14 - (nb - 13'h11c2)])
    else $error("inverted code word wrong");
  a_data_order: assert property (data_phase |-> tx_active && nb >= 13'h11d1)
    else $error("data block before preamble end");
  c_start: cover property ($rose(tx_active));
  c_zero: cover property (line_bit_strobe && !digital_tx_line_out);
  c_tenth: cover property (line_bit_strobe && nb == 13'ha);
endmodule
bind data_transmit_preamble_framer framer_checker i_checker (.clk_sys, .reset_n,
  .digital_tx_line_out, .line_bit_strobe, .tx_active, .data_phase);
`default_nettype wire

/* File: dv/line_receiver.sv */
// behavioural far-end receiver fed by the serial line
`timescale 1ns/1ps
`default_nettype none
`include "pt_framer_defs.vh"
module line_receiver (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        line_bit,
  input  wire        bit_strobe,
  output reg  [15:0] bit_count,
  output reg  [14:0] shift,
  output wire        locked,
  output wire        code_seen
);
  // one bit per strobe; no clock of its own beyond the line timing
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_count <= 16'h0;
      shift     <= 15'h0;
    end else if (bit_strobe) begin
      bit_count <= bit_count + 16'h1;
      shift     <= {shift[13:0], line_bit};
    end
  end
  assign locked    = bit_count > 16'h3 && shift[3:0] == 4'ha;
  assign code_seen = shift == `CODE_WORD;
endmodule
`default_nettype wire

/* File: hw/bit_interleaver.v */
// block interleaver: writes rows, reads columns, ping-pong banks
`timescale 1ns/1ps
`default_nettype none
`include "pt_framer_defs.vh"
module bit_interleaver (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       bit_step,
  input  wire       bit_in,
  output reg        bit_out
);
  // two banks so writing and reading never collide
  reg  [`IL_SIZE-1:0] bank_a;
  reg  [`IL_SIZE-1:0] bank_b;
  reg                 wr_sel;
  reg  [4:0]          wr_idx;
  reg  [4:0]          rd_idx;
  wire [4:0]          rd_addr;
  // column-major read of a row-major written bank
  assign rd_addr = (rd_idx % 5'd4) * 5'd8 + (rd_idx / 5'd4);

  //------------------------------------------------------------
  // bank write and read
  //------------------------------------------------------------
  // output lags input by one block; a cold start reads zeros
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bank_a  <= {`IL_SIZE{1'b0}};
      bank_b  <= {`IL_SIZE{1'b0}};
      wr_sel  <= 1'b0;
      wr_idx  <= 5'h00;
      rd_idx  <= 5'h00;
      bit_out <= 1'b0;
    end else if (bit_step) begin
      if (wr_sel) begin
        bank_b[wr_idx] <= bit_in;
        bit_out        <= bank_a[rd_addr];
      end else begin
        bank_a[wr_idx] <= bit_in;
        bit_out        <= bank_b[rd_addr];
      end
      wr_idx <= wr_idx + 5'h01;
      rd_idx <= rd_idx + 5'h01;
      if (wr_idx == 5'h1f) begin
        wr_sel <= ~wr_sel;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/data_transmit_preamble_framer.v */
// plain-text data transmit framer: phasing, code words, inverted word, data
`timescale 1ns/1ps
`default_nettype none
`include "pt_framer_defs.vh"
// Functional notes
// - each transmission is phasing, code repeats, inverted code, then data, in order.
// - opening block alternates one then zero at 16 kb/s for 256 ms.
// - then the 15-bit code word is sent thirty times back to back.
// - then one fully inverted code word, then the data block starts.
// - low-speed data is raised to 16 kb/s then interleaved.
// - data bits are XORed with the repeating code word before sending.
module data_transmit_preamble_framer (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       tx_start,
  input  wire       tx_stop,
  input  wire       data_in,
  output reg        digital_tx_line_out,
  output reg        line_bit_strobe,
  output reg        tx_active,
  output reg        data_phase,
  output reg        data_in_req
);
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_PHASE = 3'd1;
  localparam [2:0] ST_CODE  = 3'd2;
  localparam [2:0] ST_INV   = 3'd3;
  localparam [2:0] ST_DATA  = 3'd4;
  // end counts worked out as integers, then cut to counter width on purpose
  localparam integer BIT_LAST_N   = `BIT_CLKS - 1;
  localparam integer PHASE_LAST_N = `PHASE_BITS - 1;
  localparam integer CODE_LAST_N  = `CODE_LEN - 1;
  localparam integer REPS_LAST_N  = `CODE_REPS - 1;
  localparam integer RATE_LAST_N  = `RATE_FACTOR - 1;
  localparam [11:0] BIT_LAST   = BIT_LAST_N[11:0];
  localparam [12:0] PHASE_LAST = PHASE_LAST_N[12:0];
  localparam [3:0]  CODE_LAST  = CODE_LAST_N[3:0];
  localparam [4:0]  REPS_LAST  = REPS_LAST_N[4:0];
  localparam [2:0]  RATE_LAST  = RATE_LAST_N[2:0];
  localparam [14:0] CODE_WORD  = `CODE_WORD;

  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  reg  [1:0] start_sync;
  reg  [1:0] stop_sync;
  reg  [1:0] data_sync;
  // controls and data come from outside; two flops each
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_sync <= 2'b00;
      stop_sync  <= 2'b00;
      data_sync  <= 2'b00;
    end else begin
      start_sync <= {start_sync[0], tx_start};
      stop_sync  <= {stop_sync[0], tx_stop};
      data_sync  <= {data_sync[0], data_in};
    end
  end

  //------------------------------------------------------------
  // line bit timing
  //------------------------------------------------------------
  reg  [11:0] bit_cnt;
  wire        bit_tick;
  assign bit_tick = (bit_cnt == BIT_LAST);
  // free-running divider keeps every line bit the same length
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= 12'h000;
    end else if (bit_tick) begin
      bit_cnt <= 12'h000;
    end else begin
      bit_cnt <= bit_cnt + 12'h001;
    end
  end

  //------------------------------------------------------------
  // rate conversion of low-speed input
  //------------------------------------------------------------
  reg  [2:0] rate_cnt;
  reg        held_bit;
  // each input bit repeats for RATE_FACTOR line bits
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rate_cnt <= 3'h0;
      held_bit <= 1'b0;
    end else if (bit_tick) begin
      rate_cnt <= rate_cnt + 3'h1;
      if (rate_cnt == RATE_LAST) begin
        held_bit <= data_sync[1];
      end
    end
  end

  wire il_bit;
  // interleave the rate-converted stream before framing
  bit_interleaver u_interleaver (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .bit_step(bit_tick),
    .bit_in  (held_bit),
    .bit_out (il_bit)
  );

  //------------------------------------------------------------
  // framing state machine
  //------------------------------------------------------------
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [12:0] blk_cnt;
  reg  [3:0]  code_pos;
  reg  [4:0]  rep_cnt;
  reg         start_pend;

  // block sequencing only advances on line-bit boundaries
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_pend) begin
          next_state = ST_PHASE;
        end
      end
      ST_PHASE: begin
        if (blk_cnt == PHASE_LAST) begin
          next_state = ST_CODE;
        end
      end
      ST_CODE: begin
        if (code_pos == CODE_LAST && rep_cnt == REPS_LAST) begin
          next_state = ST_INV;
        end
      end
      ST_INV: begin
        if (code_pos == CODE_LAST) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (stop_sync[1]) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // start request is remembered until the next bit boundary
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_pend <= 1'b0;
    end else if (start_sync[1] && state == ST_IDLE) begin
      start_pend <= 1'b1;
    end else if (bit_tick) begin
      start_pend <= 1'b0;
    end
  end

  // counters clear on each block change, whose tick already sends the new block's first bit, so no gap bit appears
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state    <= ST_IDLE;
      blk_cnt  <= 13'h0000;
      code_pos <= 4'h0;
      rep_cnt  <= 5'h00;
    end else if (bit_tick) begin
      state <= next_state;
      if (next_state != state) begin
        blk_cnt  <= 13'h0000;
        code_pos <= 4'h0;
        rep_cnt  <= 5'h00;
      end else begin
        blk_cnt <= blk_cnt + 13'h0001;
        if (code_pos == CODE_LAST) begin
          code_pos <= 4'h0;
          rep_cnt  <= rep_cnt + 5'h01;
        end else begin
          code_pos <= code_pos + 4'h1;
        end
      end
    end
  end

  //------------------------------------------------------------
  // line output
  //------------------------------------------------------------
  // choose bit of the block about to be sent; all outputs registered
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      digital_tx_line_out <= 1'b0;
      line_bit_strobe     <= 1'b0;
      tx_active           <= 1'b0;
      data_phase          <= 1'b0;
      data_in_req         <= 1'b0;
    end else begin
      line_bit_strobe <= bit_tick && (next_state != ST_IDLE);
      data_in_req     <= bit_tick && (rate_cnt == RATE_LAST);
      if (bit_tick) begin
        tx_active  <= (next_state != ST_IDLE);
        data_phase <= (next_state == ST_DATA);
        case (next_state)
          ST_PHASE: begin
            // first bit is forced to one on entry; blk_cnt clears to zero there, so later bits follow blk_cnt[0]
            digital_tx_line_out <= (next_state != state) ? 1'b1 : blk_cnt[0];
          end
          ST_CODE: begin
            digital_tx_line_out <= (next_state != state) ? CODE_WORD[CODE_LAST]
                                   : (code_pos == CODE_LAST ? CODE_WORD[CODE_LAST]
                                   : CODE_WORD[CODE_LAST - code_pos - 4'h1]);
          end
          ST_INV: begin
            digital_tx_line_out <= (next_state != state) ? ~CODE_WORD[CODE_LAST]
                                   : ~CODE_WORD[CODE_LAST - code_pos - 4'h1];
          end
          ST_DATA: begin
            // scramble with the repeating word for a balanced duty cycle
            digital_tx_line_out <= il_bit ^ ((next_state != state) ? CODE_WORD[CODE_LAST]
                                   : (code_pos == CODE_LAST ? CODE_WORD[CODE_LAST]
                                   : CODE_WORD[CODE_LAST - code_pos - 4'h1]));
          end
          default: begin
            digital_tx_line_out <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/pt_framer_defs.vh */
// constants for the plain-text data transmit preamble framer
`ifndef PT_FRAMER_DEFS_VH
`define PT_FRAMER_DEFS_VH
// clock and line rate
`define CLK_HZ            40000000
`define LINE_BPS          16000
// one line bit lasts this many system clocks
`define BIT_CLKS          (`CLK_HZ / `LINE_BPS)
// phasing block duration in milliseconds, and in line bits
`define PHASE_MS          256
`define PHASE_BITS        ((`LINE_BPS / 1000) * `PHASE_MS)
// code word: length, repetitions and value (value is arbitrary)
`define CODE_LEN          15
`define CODE_REPS         30
`define CODE_WORD         15'h4d2b
// low-speed input oversampling: line bits per input bit
`define RATE_FACTOR       8
// interleaver: rows x cols bits
`define IL_ROWS           4
`define IL_COLS           8
`define IL_SIZE           (`IL_ROWS * `IL_COLS)
`endif
